// ==== rtl/pclfc_top.v ====
// How it works
// - Either overcurrent input sets limit latch
// - Oscillator clock pulse clears limit latch
// - Latch gives true and inverted outputs
// - At most one pulse per period
// - Output needs modulator high and limit latch low
// - Pulse passes directly; falling edge locks
// - Remember driver of last pulse
// - First new pulse goes other driver
// - 14-bit counter counts terminating events
// - Both phases feed one count
// - Top stage high after 8192 events
// - Top stage drives soft-start discharge
// - Optional hiccup counter latches shutdown
`timescale 1ns/100ps
`include "pclfc_regs.vh"
module pclfc_top #(
  parameter FAULT_W     = `PCLFC_FAULT_W,
  parameter HICCUP_W    = `PCLFC_HICCUP_W,
  parameter HICCUP_EN   = 1,
  parameter [HICCUP_W-1:0] HICCUP_LIMIT = `PCLFC_HICCUP_LIMIT
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire         oc_diff_i,
  input  wire         oc_gnd_i,
  input  wire         osc_pulse_i,
  input  wire         pwm_pulse_i,
  input  wire         fault_clr_i,
  input  wire         manual_rst_i,
  output wire         drv_a_o,
  output wire         drv_b_o,
  output wire         limit_o,
  output wire         limit_n_o,
  output wire         ss_discharge_o,
  output wire         shutdown_o,
  output wire [FAULT_W-1:0] fault_count_o
);
  // All pin inputs except nrst_i cross into clk_i first
  wire [5:0] s;
  pclfc_sync #(.W(6)) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({manual_rst_i, fault_clr_i, pwm_pulse_i, osc_pulse_i, oc_gnd_i, oc_diff_i}),
    .q_o    (s)
  );
  wire oc_s   = s[0] | s[1];
  wire osc_s  = s[2];
  wire pwm_s  = s[3];
  wire clr_s  = s[4];
  wire mrst_s = s[5];

  reg               limit_ff;
  reg               lock_ff;
  reg               pwm_d_ff;
  reg               osc_d_ff;
  reg               last_b_ff;
  reg               out_ff;
  reg               clr_d_ff;
  reg [FAULT_W-1:0] fault_ff;
  reg [HICCUP_W-1:0] hic_ff;
  reg               shut_ff;
  reg               drv_a_ff;
  reg               drv_b_ff;

  wire osc_rise  = osc_s & ~osc_d_ff;
  wire pwm_fall  = pwm_d_ff & ~pwm_s;
  wire top_bit   = fault_ff[FAULT_W-1];
  wire sat       = top_bit;
  // Terminating event: limit newly set while a pulse is live
  wire term_evt  = oc_s & ~limit_ff & pwm_s & ~lock_ff & ~osc_rise;
  // gate: modulator high and limit path low
  wire nxt_out   = pwm_s & ~limit_ff & ~oc_s & ~lock_ff & ~shut_ff & ~osc_rise;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      limit_ff  <= `PCLFC_LATCH_RST;
      lock_ff   <= 1'b0;
      pwm_d_ff  <= 1'b0;
      osc_d_ff  <= 1'b0;
      last_b_ff <= `PCLFC_STEER_RST;
      out_ff    <= 1'b0;
      clr_d_ff  <= 1'b0;
      drv_a_ff  <= 1'b0;
      drv_b_ff  <= 1'b0;
    end else begin
      pwm_d_ff <= pwm_s;
      osc_d_ff <= osc_s;
      clr_d_ff <= clr_s;
      // clear on oscillator pulse; set wins otherwise
      if (osc_rise)
        limit_ff <= 1'b0;
      else if (oc_s)
        limit_ff <= 1'b1;
      // lock after pulse end until next period
      if (osc_rise)
        lock_ff <= 1'b0;
      else if (pwm_fall || (out_ff && !nxt_out))
        lock_ff <= 1'b1;
      out_ff <= nxt_out;
      // toggle steering at each pulse start only
      if (nxt_out && !out_ff)
        last_b_ff <= ~last_b_ff;
      // First pulse after reset lands on driver A
      drv_a_ff <= nxt_out & (out_ff ? last_b_ff : ~last_b_ff);
      drv_b_ff <= nxt_out & (out_ff ? ~last_b_ff : last_b_ff);
    end
  end

  // Fault counter: clear has priority since it is the hiccup release
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_ff <= {FAULT_W{1'b0}};
    end else if (clr_s) begin
      fault_ff <= {FAULT_W{1'b0}};
    end else if (term_evt && !sat) begin
      fault_ff <= fault_ff + {{(FAULT_W-1){1'b0}}, 1'b1};
    end
    // stop at 8192, top stage stays high
  end

  // Optional hiccup counter: counts clears that end a hiccup
  wire hic_evt = clr_s & ~clr_d_ff & top_bit;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hic_ff  <= {HICCUP_W{1'b0}};
      shut_ff <= 1'b0;
    end else if (mrst_s) begin
      hic_ff  <= {HICCUP_W{1'b0}};
      shut_ff <= 1'b0;
    end else if (HICCUP_EN != 0 && hic_evt && !shut_ff) begin
      // latch shutdown at the hiccup limit
      hic_ff  <= hic_ff + {{(HICCUP_W-1){1'b0}}, 1'b1};
      if (hic_ff + {{(HICCUP_W-1){1'b0}}, 1'b1} == HICCUP_LIMIT)
        shut_ff <= 1'b1;
    end
  end

  assign drv_a_o        = drv_a_ff;
  assign drv_b_o        = drv_b_ff;
  assign limit_o        = limit_ff;
  assign limit_n_o      = ~limit_ff;
  assign ss_discharge_o = top_bit | shut_ff;
  assign shutdown_o     = shut_ff;
  assign fault_count_o  = fault_ff;
endmodule // pclfc_top

// ==== rtl/pclfc_regs.vh ====
`ifndef PCLFC_REGS_VH
`define PCLFC_REGS_VH
// Fault counter width and terminal stage
`define PCLFC_FAULT_W      14
`define PCLFC_FAULT_TOP    13
// Hiccup counter width and default limit
`define PCLFC_HICCUP_W     4
`define PCLFC_HICCUP_LIMIT 4'h8
// Reset values
`define PCLFC_LATCH_RST    1'b0
`define PCLFC_STEER_RST    1'b0
`endif

// ==== rtl/pclfc_sync.v ====
`timescale 1ns/100ps
// Two-flop synchroniser, one per bit
module pclfc_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= d_i[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate
  assign q_o = sync_ff;
endmodule // pclfc_sync

// ==== tb/pclfc_monitor.sv ====
`timescale 1ns/100ps
module pclfc_monitor #(parameter FAULT_W = 14) (
  input wire               clk_i,
  input wire               nrst_i,
  input wire               oc_diff_i,
  input wire               oc_gnd_i,
  input wire               osc_pulse_i,
  input wire               drv_a_o,
  input wire               drv_b_o,
  input wire               limit_o,
  input wire               limit_n_o,
  input wire               ss_discharge_o,
  input wire               shutdown_o,
  input wire [FAULT_W-1:0] fault_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_inv; limit_n_o == !limit_o; endproperty
  a_inv: assert property (p_inv) else $error("inv");
  property p_ss; ss_discharge_o == (fault_count_o[FAULT_W-1] | shutdown_o); endproperty
  a_ss: assert property (p_ss) else $error("ss");
  property p_one; !(drv_a_o && drv_b_o); endproperty
  a_one: assert property (p_one) else $error("one");
  property p_cut; limit_o |-> !drv_a_o && !drv_b_o; endproperty
  a_cut: assert property (p_cut) else $error("cut");
  property p_set; $rose(limit_o) |-> $past(oc_diff_i | oc_gnd_i, 3); endproperty
  a_set: assert property (p_set) else $error("set");
  property p_clr; $fell(limit_o) |-> $past(osc_pulse_i, 3) || $past(osc_pulse_i, 4); endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_step; $changed(fault_count_o) |-> fault_count_o == 0 ||
    fault_count_o == $past(fault_count_o) + 1'b1; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_hold; fault_count_o[FAULT_W-1] |=> $stable(fault_count_o) || fault_count_o == 0; endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule // pclfc_monitor
bind pclfc_top pclfc_monitor #(.FAULT_W(FAULT_W)) u_mon (.*);

// ==== tb/pclfc_far.sv ====
`timescale 1ns/100ps
module pclfc_far (
  input  wire clk_i,
  input  wire en_i,
  input  wire oc_i,
  output wire osc_o,
  output wire pwm_o,
  output wire diff_o,
  output wire gnd_o
);
  reg  [5:0] ph_ff = 6'h00;
  wire [4:0] ph = ph_ff[4:0];
  wire       oc = oc_i && ph > 5'h08 && ph < 5'h0d;
  always @(posedge clk_i) ph_ff <= ph_ff + 6'h01;
  assign osc_o = ph < 5'h02;
  assign pwm_o = en_i && ph > 5'h04 && ph < 5'h12;
  // Swap comparators each period
  assign diff_o = oc && ph_ff[5];
  assign gnd_o = oc && !ph_ff[5];
endmodule // pclfc_far

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg en = 1'b1;
  reg oc = 1'b0;
  reg fault_clr_i = 1'b0;
  reg manual_rst_i = 1'b0;
  wire osc_pulse_i, pwm_pulse_i, oc_diff_i, oc_gnd_i, drv_a_o, drv_b_o, limit_o, limit_n_o, ss_discharge_o, shutdown_o;
  wire [3:0] fault_count_o;
  integer bad_count = 0;
  integer checks = 0;
  integer n;
  always #20 clk_i = ~clk_i;
  pclfc_far u_far (.clk_i(clk_i), .en_i(en), .oc_i(oc), .osc_o(osc_pulse_i), .pwm_o(pwm_pulse_i), .diff_o(oc_diff_i),
    .gnd_o(oc_gnd_i));
  pclfc_top #(.FAULT_W(4), .HICCUP_LIMIT(4'h2)) u_dut (.*);
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task drv(input exp_a);
    begin
      for (n = 0; n < 99 && !(drv_a_o | drv_b_o); n = n + 1) @(negedge clk_i);
      chk({7'h00, drv_a_o}, {7'h00, exp_a});
      for (n = 0; n < 99 && (drv_a_o | drv_b_o); n = n + 1) @(negedge clk_i);
    end
  endtask
  task t_alt;
    begin
      drv(1'b1);
      drv(1'b0);
      @(posedge clk_i);
      en <= 1'b0;
      repeat (99) @(posedge clk_i);
      en <= 1'b1;
      drv(1'b1);
    end
  endtask
  task t_fault;
    begin
      for (n = 0; n < 99 && !osc_pulse_i; n = n + 1) @(negedge clk_i);
      @(posedge clk_i);
      oc <= 1'b1;
      repeat (160) @(posedge clk_i);
      chk({4'h0, fault_count_o}, 8'h05);
      repeat (128) @(posedge clk_i);
      fault_clr_i <= 1'b1;
      oc <= 1'b0;
      @(negedge clk_i);
      chk({3'h0, ss_discharge_o, fault_count_o}, 8'h18);
      repeat (4) @(posedge clk_i);
      fault_clr_i <= 1'b0;
      @(negedge clk_i);
      chk({3'h0, ss_discharge_o, fault_count_o}, 8'h00);
    end
  endtask
  task t_shut;
    begin
      @(posedge clk_i);
      oc <= 1'b1;
      repeat (288) @(posedge clk_i);
      fault_clr_i <= 1'b1;
      oc <= 1'b0;
      repeat (4) @(posedge clk_i);
      fault_clr_i <= 1'b0;
      @(negedge clk_i);
      chk({2'h0, shutdown_o, ss_discharge_o, fault_count_o}, 8'h30);
      repeat (64) @(negedge clk_i);
      chk({6'h00, drv_a_o, drv_b_o}, 8'h00);
      @(posedge clk_i);
      manual_rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      manual_rst_i <= 1'b0;
      @(negedge clk_i);
      chk({2'h0, shutdown_o, ss_discharge_o, fault_count_o}, 8'h00);
    end
  endtask
  task test_done;
    begin
      if (bad_count == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #80000;
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    chk({drv_a_o, drv_b_o, limit_o, ss_discharge_o, fault_count_o}, 8'h00);
    nrst_i <= 1'b1;
    t_alt;
    t_fault;
    t_shut;
    test_done;
  end
endmodule // tb_top
